// File: bench/bft_brk_model.sv
// Purpose: breaker with two trip coils
// Assumes: one clock
// Notes: stuck models a failed breaker
`timescale 1ns/1ps
`default_nettype none
module bft_brk_model (
  // clock
  input wire logic core_clk_i,
  // coil commands
  input wire logic primary_trip_i,
  input wire logic retrip_i,
  input wire logic stuck_i,
  // breaker state
  output logic relay_state_o,
  output logic open_o
);
  logic [1:0] cnt = 2'h0;
  // monitored relay follows the primary trip command
  assign relay_state_o = primary_trip_i;
  // contacts part a few cycles after a coil, never while stuck
  always @(posedge core_clk_i) begin
    if (stuck_i || !(primary_trip_i || retrip_i)) begin
      cnt <= 2'h0;
      open_o <= 1'b0;
    end else if (cnt == 2'h3) begin
      open_o <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: bench/bft_chk.sv
// Purpose: port checks for bft_top
// Assumes: sync active-low reset
// Notes: bound to every bft_top
`timescale 1ns/1ps
`default_nettype none
module bft_chk #(
  parameter TICK_CYCLES = 10,
  parameter MAG_W = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // protection outputs
  input wire logic start_o,
  input wire logic blocked_o,
  input wire logic redundant_trip_o,
  input wire logic breaker_failure_output_o,
  // bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_start_excl: assert property (!(start_o && blocked_o))
    else $error("start and blocked together");
  a_rtrip_start: assert property (redundant_trip_o |-> start_o)
    else $error("retrip without start");
  a_fail_start: assert property (breaker_failure_output_o |-> start_o)
    else $error("failure output without start");
  a_blk_quiet: assert property
    (blocked_o |-> !(redundant_trip_o || breaker_failure_output_o))
    else $error("trip output while blocked");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_wr_hold: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_wr_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
    else $error("bad write response code");
endmodule
bind bft_top bft_chk #(.TICK_CYCLES(TICK_CYCLES), .MAG_W(MAG_W)) bft_chk_inst (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .start_o(start_o), .blocked_o(blocked_o),
  .redundant_trip_o(redundant_trip_o),
  .breaker_failure_output_o(breaker_failure_output_o),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
`default_nettype wire

// File: bench/tb_top.sv
// Purpose: self-checking bench for bft_top
// Assumes: TICK_CYCLES cut to 10 cycles
// Notes: bus answers checked by a monitor from queues
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] ma = 16'h0000, mb = 16'h0000, mc = 16'h0000;
  logic [15:0] r1 = 16'h0000, r2 = 16'h0000, rc = 16'h0000;
  logic blk = 1'b0, sig = 1'b0, ptrip = 1'b0, stuck = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  wire relay, brk_open, st, bl, rt, bf, awr, wrdy, bv, arr, rv;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [3:0] outs = {bf, rt, bl, st};
  logic [33:0] qr[$], qb[$];
  logic [8:0] rnd;
  int seed = 32'h13fa_214c;
  int compares = 0, miscompares = 0;
  logic [7:0] mt [13] = '{8'h09, 8'h06, 8'h13, 8'h25, 8'h32, 8'h48, 8'h55, 8'h64, 8'h73,
    8'h83, 8'h95, 8'hac, 8'haf};
  always #5 clk = ~clk;
  bft_top #(.TICK_CYCLES(10)) bft_top_inst (
    .core_clk_i(clk), .rstn_i(rstn), .phase_a_mag_i(ma), .phase_b_mag_i(mb), .phase_c_mag_i(mc),
    .residual_input_one_i(r1), .residual_input_two_i(r2), .residual_calculated_i(rc),
    .block_i(blk), .signal_trip_i(sig), .relay_trip_i(relay), .start_o(st), .blocked_o(bl),
    .redundant_trip_o(rt), .breaker_failure_output_o(bf), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
  bft_brk_model bft_brk_model_inst (.core_clk_i(clk), .primary_trip_i(ptrip), .retrip_i(rt),
    .stuck_i(stuck), .relay_state_o(relay), .open_o(brk_open));
  task automatic chk(input string n, input [33:0] e, input [33:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ready is raised only once the answer is seen, so the hold checks get exercised
  task automatic wr(input [11:0] a, input [31:0] d, input [1:0] r);
    qb.push_back({r, 32'h0000_0000});
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) bry <= 1'b1;
    end while (!(bv && bry));
    bry <= 1'b0;
  endtask
  task automatic rd(input [11:0] a, input [33:0] e);
    qr.push_back(e);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) rry <= 1'b1;
    end while (!(rv && rry));
    rry <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (rv && rry) chk("read", qr.pop_front(), {rr, rdat});
    if (bv && bry) chk("bresp", qb.pop_front(), {br, 32'h0000_0000});
  end
  task automatic wt(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (outs[i] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk($sformatf("out%0d", i), {33'h0, v}, {33'h0, outs[i]});
  endtask
  task automatic hold(input int i, input logic v, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (outs[i] !== v) bad = 1'b1;
    end
    chk($sformatf("steady%0d", i), 34'h0, {33'h0, bad});
  endtask
  task automatic drive(input logic c, input logic s, input logic p);
    rnd = 9'($random(seed));
    @(posedge clk);
    mb <= c ? 16'h00c9 + {7'h00, rnd} : 16'h0000;
    sig <= s;
    ptrip <= p;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(12'h000, 34'h0_0000_0100);
    rd(12'h004, 34'h0_0000_00c8);
    rd(12'h008, 34'h0_0000_04b0);
    rd(12'h00c, 34'h0_0000_0014);
    rd(12'h010, 34'h0_0000_0028);
    rd(12'h020, 34'h2_0000_0000);
    wr(12'h014, 32'h0000_00ff, 2'b10);
    wr(12'h020, 32'h0000_0001, 2'b10);
    wr(12'h00c, 32'h0000_0003, 2'b00);
    wr(12'h010, 32'h0000_0006, 2'b00);
    $display("test registers done");
    drive(1'b1, 1'b0, 1'b0);
    wt(0, 1'b1, 40);
    wt(2, 1'b1, 60);
    wt(3, 1'b0, 0);
    wt(3, 1'b1, 60);
    rd(12'h014, 34'h0_0000_0073);
    stuck <= 1'b0;
    while (!brk_open) @(posedge clk);
    drive(1'b0, 1'b0, 1'b0);
    wt(0, 1'b0, 40);
    @(posedge clk);
    chk("idle", 34'h0, {30'h0, outs});
    @(posedge clk);
    mc <= 16'h00c9;
    wt(0, 1'b1, 40);
    @(posedge clk);
    mc <= 16'h00c2;
    hold(0, 1'b1, 40);
    @(posedge clk);
    mc <= 16'h00c1;
    wt(0, 1'b0, 40);
    $display("test current done");
    blk <= 1'b1;
    repeat (30) @(posedge clk);
    drive(1'b1, 1'b0, 1'b0);
    wt(1, 1'b1, 40);
    rd(12'h014, 34'h0_0000_0085);
    hold(0, 1'b0, 40);
    drive(1'b0, 1'b0, 1'b0);
    blk <= 1'b0;
    wt(1, 1'b0, 40);
    // the cleared block must be sampled at a tick before pick-up returns
    repeat (30) @(posedge clk);
    drive(1'b1, 1'b0, 1'b0);
    wt(0, 1'b1, 40);
    blk <= 1'b1;
    wt(0, 1'b0, 30);
    hold(2, 1'b0, 60);
    drive(1'b0, 1'b0, 1'b0);
    blk <= 1'b0;
    $display("test blocking done");
    for (int s = 0; s < 4; s++) begin
      wr(12'h000, 32'h0000_0100 | (s << 4), 2'b00);
      @(posedge clk);
      r1 <= (s < 2) ? 16'h04b1 : 16'h0000;
      r2 <= (s == 0 || s == 2) ? 16'h04b1 : 16'h0000;
      rc <= (s == 0 || s == 3) ? 16'h04b1 : 16'h0000;
      wt(0, s != 0, 40);
      hold(0, s != 0, 20);
      @(posedge clk);
      {r1, r2, rc} <= 48'h0000_0000_0000;
      wt(0, 1'b0, 40);
    end
    $display("test residual done");
    foreach (mt[k]) begin
      wr(12'h000, {23'h00_0000, 1'b1, 4'h0, mt[k][7:4]}, 2'b00);
      drive(mt[k][3], mt[k][2], mt[k][1]);
      wt(0, mt[k][0], 40);
      hold(0, mt[k][0], 10);
      drive(1'b0, 1'b0, 1'b0);
      wt(0, 1'b0, 40);
    end
    wr(12'h000, 32'h0000_0103, 2'b00);
    drive(1'b1, 1'b0, 1'b0);
    wt(0, 1'b1, 40);
    hold(2, 1'b0, 80);
    drive(1'b1, 1'b0, 1'b1);
    wt(2, 1'b1, 60);
    drive(1'b0, 1'b0, 1'b0);
    wt(0, 1'b0, 40);
    $display("test modes done");
    wr(12'h000, 32'h0000_0000, 2'b00);
    drive(1'b1, 1'b0, 1'b0);
    hold(2, 1'b0, 50);
    wt(3, 1'b1, 60);
    drive(1'b0, 1'b0, 1'b0);
    wt(0, 1'b0, 40);
    $display("test retrip disable done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: design/bft_top.v
// Purpose: breaker failure pick-up, blocking and two delay timers
// Assumes: magnitudes arrive as 16-bit words in 0.001 x nominal units
// Notes: delays count in 5 ms processing ticks; registers over AXI4-Lite
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bft_consts.vh"
module bft_top #(
  parameter TICK_CYCLES = `BFT_TICK_CYCLES,
  parameter MAG_W = 16
) (
  // clock and reset
  input wire core_clk_i,
  input wire rstn_i,
  // measured magnitudes
  input wire [MAG_W-1:0] phase_a_mag_i,
  input wire [MAG_W-1:0] phase_b_mag_i,
  input wire [MAG_W-1:0] phase_c_mag_i,
  input wire [MAG_W-1:0] residual_input_one_i,
  input wire [MAG_W-1:0] residual_input_two_i,
  input wire [MAG_W-1:0] residual_calculated_i,
  // binary inputs from outside the clock domain
  input wire block_i,
  input wire signal_trip_i,
  input wire relay_trip_i,
  // outputs
  output reg start_o,
  output reg blocked_o,
  output reg redundant_trip_o,
  output reg breaker_failure_output_o,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // settings registers
  reg [31:0] ctrl;
  reg [15:0] phase_thr;
  reg [15:0] res_thr;
  reg [19:0] rtrip_dly;
  reg [19:0] bf_dly;
  wire [3:0] mode = ctrl[`BFT_MODE_LSB +: 4];
  wire [1:0] res_sel = ctrl[`BFT_RES_SEL_LSB +: 2];
  wire rtrip_en = ctrl[`BFT_RTRIP_EN_BIT];

  // pin synchronisers: three stages, change counts when stages 2 and 3 agree
  // a one-stage glitch on a pin never reaches the protection logic
  wire [2:0] pin_raw = {relay_trip_i, signal_trip_i, block_i};
  wire [2:0] pin_q;
  genvar si;
  generate
    for (si = 0; si < 3; si = si + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg q;
      always @(posedge core_clk_i) begin
        if (!rstn_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          q <= 1'b0;
        end else begin
          s1 <= pin_raw[si];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            q <= s3;
          end
        end
      end
      assign pin_q[si] = q;
    end
  endgenerate

  // processing tick; a wide counter covers the 5 ms tick at full clock rate
  reg [31:0] tick_cnt;
  reg tick;
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // block sampled once at each tick and held for the cycle
  // a block change between ticks waits for the next tick to count
  reg block_s;
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      block_s <= 1'b0;
    end else if (tick) begin
      block_s <= pin_q[0];
    end
  end

  // magnitude comparators with 97 percent drop-out
  wire [MAG_W-1:0] mags [0:3];
  assign mags[0] = phase_a_mag_i;
  assign mags[1] = phase_b_mag_i;
  assign mags[2] = phase_c_mag_i;
  assign mags[3] = (res_sel == `BFT_RES_ONE) ? residual_input_one_i :
                   (res_sel == `BFT_RES_TWO) ? residual_input_two_i :
                   residual_calculated_i;
  // magnitude scaled by 100 against threshold by 97, so no divider is needed
  wire [23:0] ph_drop = phase_thr * 8'd97;
  wire [23:0] rs_drop = res_thr * 8'd97;
  wire [3:0] pick;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
      // phases share one threshold; drop-out ratio stays tied to it
      wire [15:0] thr = (gi < 3) ? phase_thr : res_thr;
      wire [23:0] drop = (gi < 3) ? ph_drop : rs_drop;
      wire [23:0] scaled = mags[gi] * 8'd100;
      wire en = (gi < 3) ? 1'b1 : (res_sel != `BFT_RES_UNUSED);
      reg pk;
      always @(posedge core_clk_i) begin
        if (!rstn_i) begin
          pk <= 1'b0;
        end else if (!en) begin
          pk <= 1'b0;
        end else if (mags[gi] > thr) begin
          pk <= 1'b1;
        end else if (scaled < drop) begin
          pk <= 1'b0;
        end
      end
      assign pick[gi] = pk;
    end
  endgenerate
  wire cur = |pick;
  wire sig = pin_q[1];
  wire dout = pin_q[2];

  // mode combination; hold means pick-up present but timing halted
  reg pu;
  reg hold;
  always @* begin
    pu = cur;
    hold = 1'b0;
    case (mode)
      `BFT_MODE_CUR: begin
        pu = cur;
      end
      `BFT_MODE_DO: begin
        pu = dout;
      end
      `BFT_MODE_SIG: begin
        pu = sig;
      end
      `BFT_MODE_CUR_AND_DO: begin
        pu = cur;
        hold = cur & ~dout;
      end
      `BFT_MODE_CUR_AND_SIG: begin
        pu = cur & sig;
      end
      `BFT_MODE_CUR_OR_SIG: begin
        pu = cur | sig;
      end
      `BFT_MODE_SIG_AND_DO: begin
        pu = sig & dout;
      end
      `BFT_MODE_SIG_OR_DO: begin
        pu = sig | dout;
      end
      `BFT_MODE_CUR_OR_DO: begin
        pu = cur | dout;
      end
      `BFT_MODE_ALL_OR: begin
        pu = cur | sig | dout;
      end
      `BFT_MODE_ALL_AND: begin
        pu = cur & sig & dout;
      end
      default: begin
        pu = cur;
      end
    endcase
  end

  // start, blocked and timers
  reg [19:0] rt_cnt;
  reg [19:0] bf_cnt;
  reg [2:0] cond;
  // a zero delay trips on the first cycle of start
  wire rt_done = (rt_cnt >= rtrip_dly);
  wire bf_done = (bf_cnt >= bf_dly);
  // once blocked, pick-up must fall away before a new start is possible
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      start_o <= 1'b0;
      blocked_o <= 1'b0;
      redundant_trip_o <= 1'b0;
      breaker_failure_output_o <= 1'b0;
      rt_cnt <= 20'h0_0000;
      bf_cnt <= 20'h0_0000;
      cond <= `BFT_COND_NORMAL;
    end else if (!pu || block_s) begin
      // release path, also taken when blocking arrives later
      start_o <= 1'b0;
      blocked_o <= pu & block_s & ~start_o;
      redundant_trip_o <= 1'b0;
      breaker_failure_output_o <= 1'b0;
      rt_cnt <= 20'h0_0000;
      bf_cnt <= 20'h0_0000;
      cond <= (pu && block_s) ? `BFT_COND_BLOCKED : `BFT_COND_NORMAL;
    end else if (!blocked_o) begin
      start_o <= 1'b1;
      if (tick && !hold) begin
        // both counters run off one qualified pick-up
        // counts stop at the delay so a long fault cannot wrap them
        if (!rt_done) begin
          rt_cnt <= rt_cnt + 20'h0_0001;
        end
        if (!bf_done) begin
          bf_cnt <= bf_cnt + 20'h0_0001;
        end
      end
      redundant_trip_o <= rtrip_en & rt_done;
      breaker_failure_output_o <= bf_done;
      if (bf_done) cond <= `BFT_COND_BF;
      else if (rtrip_en && rt_done) cond <= `BFT_COND_RTRIP;
      else cond <= `BFT_COND_START;
    end
  end

  // axi4-lite write; settings take effect live, no restart
  reg aw_got;
  reg w_got;
  reg [11:0] aw_q;
  reg [31:0] w_q;
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl <= `BFT_CTRL_RESET;
      phase_thr <= `BFT_PHASE_THR_RESET;
      res_thr <= `BFT_RES_THR_RESET;
      rtrip_dly <= `BFT_RTRIP_DLY_RESET;
      bf_dly <= `BFT_BF_DLY_RESET;
    end else begin
      s_axi_awready <= ~aw_got & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_got & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        // strobes ignored: each setting is written as a whole word
        case (aw_q)
          `BFT_OFF_CTRL: ctrl <= {23'h00_0000, w_q[8:0]};
          `BFT_OFF_PHASE_THR: phase_thr <= w_q[15:0];
          `BFT_OFF_RES_THR: res_thr <= w_q[15:0];
          `BFT_OFF_RTRIP_DLY: rtrip_dly <= w_q[19:0];
          `BFT_OFF_BF_DLY: bf_dly <= w_q[19:0];
          // the status word only reports, so a write to it is refused
          `BFT_OFF_STATUS: s_axi_bresp <= 2'h2;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
    end
  end

  // status word: blocked, failure, retrip, start, spare zero, condition
  wire [31:0] status_word = {
    24'h00_0000,
    blocked_o,
    breaker_failure_output_o,
    redundant_trip_o,
    start_o,
    1'b0,
    cond
  };

  // axi4-lite read; data stands one cycle after the address is taken
  always @(posedge core_clk_i) begin
    if (!rstn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `BFT_OFF_CTRL: s_axi_rdata <= ctrl;
          `BFT_OFF_PHASE_THR: s_axi_rdata <= {16'h0000, phase_thr};
          `BFT_OFF_RES_THR: s_axi_rdata <= {16'h0000, res_thr};
          `BFT_OFF_RTRIP_DLY: s_axi_rdata <= {12'h000, rtrip_dly};
          `BFT_OFF_BF_DLY: s_axi_rdata <= {12'h000, bf_dly};
          `BFT_OFF_STATUS: s_axi_rdata <= status_word;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: inc/bft_consts.vh
// Purpose: constants for the breaker failure timer block
// Assumes: 100 MHz core clock, AXI4-Lite register access
// Notes: thresholds in units of 0.001 x nominal current
`ifndef BFT_CONSTS_VH
`define BFT_CONSTS_VH
`define BFT_OFF_CTRL 12'h000
`define BFT_OFF_PHASE_THR 12'h004
`define BFT_OFF_RES_THR 12'h008
`define BFT_OFF_RTRIP_DLY 12'h00c
`define BFT_OFF_BF_DLY 12'h010
`define BFT_OFF_STATUS 12'h014
`define BFT_CTRL_RESET 32'h0000_0100
`define BFT_PHASE_THR_RESET 16'h00c8
`define BFT_RES_THR_RESET 16'h04b0
`define BFT_RTRIP_DLY_RESET 20'h0_0014
`define BFT_BF_DLY_RESET 20'h0_0028
`define BFT_MODE_LSB 0
`define BFT_RES_SEL_LSB 4
`define BFT_RTRIP_EN_BIT 8
`define BFT_RES_UNUSED 2'h0
`define BFT_RES_ONE 2'h1
`define BFT_RES_TWO 2'h2
`define BFT_RES_CALC 2'h3
`define BFT_MODE_CUR 4'h0
`define BFT_MODE_DO 4'h1
`define BFT_MODE_SIG 4'h2
`define BFT_MODE_CUR_AND_DO 4'h3
`define BFT_MODE_CUR_AND_SIG 4'h4
`define BFT_MODE_CUR_OR_SIG 4'h5
`define BFT_MODE_SIG_AND_DO 4'h6
`define BFT_MODE_SIG_OR_DO 4'h7
`define BFT_MODE_CUR_OR_DO 4'h8
`define BFT_MODE_ALL_OR 4'h9
`define BFT_MODE_ALL_AND 4'ha
`define BFT_COND_NORMAL 3'h0
`define BFT_COND_START 3'h1
`define BFT_COND_RTRIP 3'h2
`define BFT_COND_BF 3'h3
`define BFT_COND_ON 3'h4
`define BFT_COND_BLOCKED 3'h5
`define BFT_RESET_PCT 97
`define BFT_DLY_STEP_US 5000
`define BFT_CLK_MHZ 100
`define BFT_TICK_CYCLES (`BFT_DLY_STEP_US * `BFT_CLK_MHZ)
`endif
